// ### rtl/scs_pkg.sv
// constants for the reduced system control space: addresses, bit fields, reset values
// assumes a 32-bit byte-addressed register bus; every register is one aligned word
package scs_pkg;
	// reserved locations
	localparam logic [31:0] SYS_CTRL_RSVD     = 32'hE000_ED10;
	localparam logic [31:0] CFG_CTRL_RSVD     = 32'hE000_ED14;
	localparam logic [31:0] HPRIO1_RSVD       = 32'hE000_ED18;
	localparam logic [31:0] CFG_FAULT_RSVD    = 32'hE000_ED28;
	localparam logic [31:0] SEV_FAULT_RSVD    = 32'hE000_ED2C;
	localparam logic [31:0] MEM_FADDR_RSVD    = 32'hE000_ED34;
	localparam logic [31:0] BUS_FADDR_RSVD    = 32'hE000_ED38;
	localparam logic [31:0] AUX_FAULT_RSVD    = 32'hE000_ED3C;
	localparam logic [31:0] ATTR_REGION_LO    = 32'hE000_ED40;
	localparam logic [31:0] ATTR_REGION_HI    = 32'hE000_ED7F;
	localparam logic [31:0] COPROC_RSVD       = 32'hE000_ED88;
	localparam logic [31:0] SW_TRIG_RSVD      = 32'hE000_EF00;
	// implemented registers
	localparam logic [31:0] APP_INTERRUPT_RESET_CTRL_ADDR        = 32'hE000_ED0C;
	localparam logic [31:0] HANDLER_CTRL_STATE_REG_ADDR        = 32'hE000_ED24;
	localparam logic [31:0] DEBUG_FAULT_STATUS_REG_ADDR         = 32'hE000_ED30;
	localparam logic [31:0] DBG_CTRL_ADDR     = 32'hE000_EDF0;
	localparam logic [31:0] PC_SAMPLE_REG_ADDR         = 32'hE000_101C;
	localparam logic [31:0] WATCH_BASE        = 32'hE000_1020;
	localparam logic [31:0] BREAKPOINT_INSTRUCTION_BASE         = 32'hE000_2008;
	localparam logic [31:0] TICK_CTRL_ADDR    = 32'hE000_E010;
	localparam logic [31:0] TICK_RELOAD_ADDR  = 32'hE000_E014;
	localparam logic [31:0] TICK_CUR_ADDR     = 32'hE000_E018;
	// fields
	localparam int PRIORITY_GROUP_FIELD_LSB     = 8;
	localparam int PRIORITY_GROUP_FIELD_W       = 3;
	localparam int SYSRESET_BIT     = 2;
	localparam int HANDLER_CTRL_STATE_REG_SEVERE_BIT = 0;
	localparam int DEBUG_FAULT_STATUS_REG_HALTED_BIT  = 0;
	localparam int DEBUG_FAULT_STATUS_REG_BREAKPOINT_INSTRUCTION_BIT    = 1;
	localparam int DEBUG_FAULT_STATUS_REG_WATCH_BIT   = 2;
	localparam int DEBUG_FAULT_STATUS_REG_W           = 3;
	localparam int DBGC_EN_BIT      = 0;
	localparam int DBGC_HALT_BIT    = 1;
	localparam int DBGC_HALTED_BIT  = 17;
	localparam int COMP_EN_BIT      = 0;
	localparam int TICK_EN_BIT      = 0;
	localparam int TICK_IE_BIT      = 1;
	localparam int TICK_FLAG_BIT    = 16;
	localparam int TICK_W           = 24;
	localparam int MAX_IRQ          = 32;
	localparam int MAX_PRIO_BITS    = 7;
	// reset values and bus answers
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
endpackage : scs_pkg

// ### rtl/addr_match.sv
// one address comparator for the breakpoint and watchpoint units
// assumes probe inputs are synchronous to mclk; bit 0 of the reference is the enable
`timescale 1ns/1ps
`default_nettype none
module addr_match
	import scs_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        active,
	input  wire logic [31:0] ref_addr,
	input  wire logic        probe_valid,
	input  wire logic [31:0] probe_addr,
	output logic             hit_q
);
	// halfword granule: bit 0 of the address carries the enable, so it is not compared
	always_ff @(posedge mclk) begin
		if (rst) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= active && ref_addr[COMP_EN_BIT] && probe_valid
				&& (ref_addr[31:1] == probe_addr[31:1]);
		end
	end
endmodule : addr_match
`default_nettype wire

// ### rtl/tick_timer.sv
// optional down-counting system tick timer with reload and sticky wrap flag
// assumes control strobes are single-cycle pulses from the register bank
`timescale 1ns/1ps
`default_nettype none
module tick_timer
	import scs_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              run,
	input  wire logic              reload_wr,
	input  wire logic [TICK_W-1:0] reload_val,
	input  wire logic              cur_clr,
	input  wire logic              flag_clr,
	output logic [TICK_W-1:0]      reload_q,
	output logic [TICK_W-1:0]      cur_q,
	output logic                   flag_q,
	output logic                   wrap_q
);
	logic wrap;
	assign wrap = run && (cur_q == TICK_W'(1));

	// reload value store
	always_ff @(posedge mclk) begin
		if (rst) begin
			reload_q <= '0;
		end else if (reload_wr) begin
			reload_q <= reload_val;
		end
	end

	// counter: zero reloads on the next edge, so a reload of n gives a period of n+1
	always_ff @(posedge mclk) begin
		if (rst || cur_clr) begin
			cur_q <= '0;
		end else if (run) begin
			cur_q <= (cur_q == '0) ? reload_q : cur_q - TICK_W'(1);
		end
	end

	// sticky wrap flag; a wrap in the clearing cycle wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			flag_q <= 1'b0;
			wrap_q <= 1'b0;
		end else begin
			flag_q <= wrap | (flag_q & ~flag_clr);
			wrap_q <= wrap;
		end
	end
endmodule : tick_timer
`default_nettype wire

// ### rtl/reduced_system_control_space.sv
// reduced system control space register bank behind an AXI4-Lite slave
// assumes one write and one read under way at most; core-side events are synchronous
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module reduced_system_control_space
	import scs_pkg::*;
#(
	parameter int NUM_IRQ   = 32,
	parameter int PRIO_BITS = 2,
	parameter int NUM_BREAKPOINT_INSTRUCTION  = 4,
	parameter int NUM_WATCH = 2,
	parameter bit DEBUG_EXT = 1'b1,
	parameter bit PC_SAMPLE_REG_EN   = 1'b1,
	parameter bit TICK_EN   = 1'b1
)
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [31:0] araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	input  wire logic        debug_port_sel,
	input  wire logic        memory_manage_fault,
	input  wire logic        bus_error_fault,
	input  wire logic        usage_error_fault,
	input  wire logic        other_fault,
	output logic             severe_fault,
	output logic             stack_align_enforce,
	output logic             misaligned_access_trap,
	input  wire logic        fetch_valid,
	input  wire logic [31:0] fetch_addr,
	input  wire logic        data_valid,
	input  wire logic [31:0] data_addr,
	input  wire logic        breakpoint_instruction,
	input  wire logic        core_halted,
	input  wire logic [31:0] pc_sample,
	output logic             core_halt_req,
	output logic             sys_reset_req,
	output logic             tick_event
);
	// elaboration checks on sizes the logic cannot serve
	if (NUM_IRQ < 1 || NUM_IRQ > MAX_IRQ) begin : g_bad_irq
		$error("interrupt count must be 1 to 32");
	end
	if (PRIO_BITS < 1 || PRIO_BITS > MAX_PRIO_BITS) begin : g_bad_prio
		$error("priority width must be 1 to 7 bits");
	end
	if (NUM_BREAKPOINT_INSTRUCTION < 1 || NUM_BREAKPOINT_INSTRUCTION > 8 || NUM_WATCH < 1 || NUM_WATCH > 4) begin : g_bad_comp
		$error("comparator counts out of range");
	end

	// alignment functions are fixed on in hardware, nothing can turn them off
	assign stack_align_enforce    = 1'b1;
	assign misaligned_access_trap = 1'b1;

	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : strb_mask

	// reserved words and the attribute region: only the assertions look at this
	function automatic logic is_rsvd(input logic [31:0] a);
		is_rsvd = (a == SYS_CTRL_RSVD) || (a == CFG_CTRL_RSVD) || (a == HPRIO1_RSVD)
			|| (a == CFG_FAULT_RSVD) || (a == SEV_FAULT_RSVD) || (a == AUX_FAULT_RSVD)
			|| (a == MEM_FADDR_RSVD) || (a == BUS_FADDR_RSVD) || (a == COPROC_RSVD)
			|| (a == SW_TRIG_RSVD) || (a >= ATTR_REGION_LO && a <= ATTR_REGION_HI);
	endfunction : is_rsvd

	logic              aw_held_q, w_held_q, bvalid_q, rvalid_q;
	logic [31:0]       aw_addr_q, w_data_q, rdata_q;
	logic [3:0]        w_strb_q;
	logic              aw_take, w_take, ar_take, wr_fire;
	logic [31:0]       wr_addr, wr_data, wr_mask, wr_bits, rd_val;
	logic              dbg_ok, dbg_wr, debug_en;
	logic              handler_ctrl_state_reg_q, dbg_en_q, dbg_halt_q, evt_halt_q, halt_req_q;
	logic              core_halted_q, severe_q, sysrst_q;
	logic [DEBUG_FAULT_STATUS_REG_W-1:0] debug_fault_status_reg_q, debug_fault_status_reg_set;
	logic [31:0]       breakpoint_instruction_q [NUM_BREAKPOINT_INSTRUCTION];
	logic [31:0]       watch_q [NUM_WATCH];
	logic [NUM_BREAKPOINT_INSTRUCTION-1:0]  breakpoint_instruction_hit;
	logic [NUM_WATCH-1:0] watch_hit;
	logic              any_fault, breakpoint_instruction_evt, watch_evt;
	logic              tick_run_q, tick_ie_q;
	logic [TICK_W-1:0] tick_reload, tick_cur;
	logic              tick_flag, tick_wrap;

	// bus handshake: address and data are accepted in either order
	assign awready = !aw_held_q && !bvalid_q;
	assign wready  = !w_held_q && !bvalid_q;
	assign arready = !rvalid_q;
	assign aw_take = awvalid && awready;
	assign w_take  = wvalid && wready;
	assign ar_take = arvalid && arready;
	assign wr_fire = (aw_held_q || aw_take) && (w_held_q || w_take);
	assign wr_addr = aw_held_q ? aw_addr_q : awaddr;
	assign wr_data = w_held_q ? w_data_q : wdata;
	assign wr_mask = strb_mask(w_held_q ? w_strb_q : wstrb);
	assign wr_bits = wr_data & wr_mask;
	assign bvalid  = bvalid_q;
	assign bresp   = RESP_OKAY;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = RESP_OKAY;

	// debug resources only answer on the debug access path
	assign dbg_ok   = DEBUG_EXT && debug_port_sel;
	assign dbg_wr   = wr_fire && dbg_ok;
	assign debug_en = DEBUG_EXT && dbg_en_q;

	// write channel state
	always_ff @(posedge mclk) begin
		if (rst) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			aw_addr_q <= WORD_RESET;
			w_data_q  <= WORD_RESET;
			w_strb_q  <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_addr_q <= awaddr;
			end
			if (w_take) begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			aw_held_q <= (aw_held_q || aw_take) && !wr_fire;
			w_held_q  <= (w_held_q || w_take) && !wr_fire;
			bvalid_q  <= wr_fire || (bvalid_q && !bready);
		end
	end

	// read mux: anything not listed here, reserved words included, reads zero
	always_comb begin
		rd_val = WORD_RESET;
		if (araddr == APP_INTERRUPT_RESET_CTRL_ADDR) begin
			rd_val[PRIORITY_GROUP_FIELD_LSB +: PRIORITY_GROUP_FIELD_W] = '0;
		end
		if (dbg_ok && araddr == HANDLER_CTRL_STATE_REG_ADDR) begin
			rd_val[HANDLER_CTRL_STATE_REG_SEVERE_BIT] = handler_ctrl_state_reg_q;
		end
		if (dbg_ok && araddr == DEBUG_FAULT_STATUS_REG_ADDR) begin
			rd_val[DEBUG_FAULT_STATUS_REG_W-1:0] = debug_fault_status_reg_q;
		end
		if (dbg_ok && araddr == DBG_CTRL_ADDR) begin
			rd_val[DBGC_EN_BIT]     = dbg_en_q;
			rd_val[DBGC_HALT_BIT]   = dbg_halt_q;
			rd_val[DBGC_HALTED_BIT] = core_halted_q;
		end
		if (dbg_ok && PC_SAMPLE_REG_EN && araddr == PC_SAMPLE_REG_ADDR) begin
			rd_val = pc_sample;
		end
		for (int i = 0; i < NUM_BREAKPOINT_INSTRUCTION; i++) begin
			if (dbg_ok && araddr == BREAKPOINT_INSTRUCTION_BASE + 32'(4 * i)) begin
				rd_val = breakpoint_instruction_q[i];
			end
		end
		for (int i = 0; i < NUM_WATCH; i++) begin
			if (dbg_ok && araddr == WATCH_BASE + 32'(4 * i)) begin
				rd_val = watch_q[i];
			end
		end
		if (TICK_EN && araddr == TICK_CTRL_ADDR) begin
			rd_val[TICK_EN_BIT]   = tick_run_q;
			rd_val[TICK_IE_BIT]   = tick_ie_q;
			rd_val[TICK_FLAG_BIT] = tick_flag;
		end
		if (TICK_EN && araddr == TICK_RELOAD_ADDR) begin
			rd_val[TICK_W-1:0] = tick_reload;
		end
		if (TICK_EN && araddr == TICK_CUR_ADDR) begin
			rd_val[TICK_W-1:0] = tick_cur;
		end
	end

	// read channel: data captured at address acceptance, held until rready
	always_ff @(posedge mclk) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= WORD_RESET;
		end else begin
			if (ar_take) begin
				rdata_q <= rd_val;
			end
			rvalid_q <= ar_take || (rvalid_q && !rready);
		end
	end

	// fault escalation: every category becomes one severe fault; a breakpoint
	// instruction with debug off has nowhere else to go and escalates too
	assign any_fault = memory_manage_fault || bus_error_fault || usage_error_fault
		|| other_fault || (breakpoint_instruction && !debug_en);
	always_ff @(posedge mclk) begin
		if (rst) begin
			severe_q <= 1'b0;
		end else begin
			severe_q <= any_fault;
		end
	end
	assign severe_fault = severe_q;

	// sticky severe-fault state, write one to clear, a new fault wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			handler_ctrl_state_reg_q <= 1'b0;
		end else begin
			handler_ctrl_state_reg_q <= severe_q
				| (handler_ctrl_state_reg_q & ~(dbg_wr && wr_addr == HANDLER_CTRL_STATE_REG_ADDR && wr_bits[HANDLER_CTRL_STATE_REG_SEVERE_BIT]));
		end
	end

	// breakpoint and watchpoint comparators
	for (genvar g = 0; g < NUM_BREAKPOINT_INSTRUCTION; g++) begin : g_breakpoint_instruction
		addr_match u_breakpoint_instruction (
			.mclk        (mclk),
			.rst         (rst),
			.active      (debug_en),
			.ref_addr    (breakpoint_instruction_q[g]),
			.probe_valid (fetch_valid),
			.probe_addr  (fetch_addr),
			.hit_q       (breakpoint_instruction_hit[g])
		);
	end
	for (genvar g = 0; g < NUM_WATCH; g++) begin : g_watch
		addr_match u_watch (
			.mclk        (mclk),
			.rst         (rst),
			.active      (debug_en),
			.ref_addr    (watch_q[g]),
			.probe_valid (data_valid),
			.probe_addr  (data_addr),
			.hit_q       (watch_hit[g])
		);
	end

	// comparator references, byte lanes honoured
	always_ff @(posedge mclk) begin
		if (rst) begin
			for (int i = 0; i < NUM_BREAKPOINT_INSTRUCTION; i++) begin
				breakpoint_instruction_q[i] <= WORD_RESET;
			end
			for (int i = 0; i < NUM_WATCH; i++) begin
				watch_q[i] <= WORD_RESET;
			end
		end else if (dbg_wr) begin
			for (int i = 0; i < NUM_BREAKPOINT_INSTRUCTION; i++) begin
				if (wr_addr == BREAKPOINT_INSTRUCTION_BASE + 32'(4 * i)) begin
					breakpoint_instruction_q[i] <= (breakpoint_instruction_q[i] & ~wr_mask) | wr_bits;
				end
			end
			for (int i = 0; i < NUM_WATCH; i++) begin
				if (wr_addr == WATCH_BASE + 32'(4 * i)) begin
					watch_q[i] <= (watch_q[i] & ~wr_mask) | wr_bits;
				end
			end
		end
	end

	// debug events: halting only, there is no monitor exception path
	assign breakpoint_instruction_evt  = debug_en && ((|breakpoint_instruction_hit) || breakpoint_instruction);
	assign watch_evt = debug_en && (|watch_hit);
	assign debug_fault_status_reg_set  = {watch_evt, breakpoint_instruction_evt, core_halted && !core_halted_q};

	// debug fault status, write one to clear, set wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			debug_fault_status_reg_q        <= '0;
			core_halted_q <= 1'b0;
		end else begin
			core_halted_q <= core_halted;
			if (dbg_wr && wr_addr == DEBUG_FAULT_STATUS_REG_ADDR) begin
				debug_fault_status_reg_q <= debug_fault_status_reg_set | (debug_fault_status_reg_q & ~wr_bits[DEBUG_FAULT_STATUS_REG_W-1:0]);
			end else begin
				debug_fault_status_reg_q <= debug_fault_status_reg_set | debug_fault_status_reg_q;
			end
		end
	end

	// debug control and halt request; an event halt drops once the core has halted
	always_ff @(posedge mclk) begin
		if (rst) begin
			dbg_en_q   <= 1'b0;
			dbg_halt_q <= 1'b0;
			evt_halt_q <= 1'b0;
			halt_req_q <= 1'b0;
		end else begin
			if (dbg_wr && wr_addr == DBG_CTRL_ADDR && wr_mask[0]) begin
				dbg_en_q   <= wr_data[DBGC_EN_BIT];
				dbg_halt_q <= wr_data[DBGC_HALT_BIT];
			end
			evt_halt_q <= breakpoint_instruction_evt || watch_evt || (evt_halt_q && !core_halted);
			halt_req_q <= debug_en && (dbg_halt_q || evt_halt_q);
		end
	end
	assign core_halt_req = halt_req_q;

	// system reset request from the control word; no priority grouping state exists
	always_ff @(posedge mclk) begin
		if (rst) begin
			sysrst_q <= 1'b0;
		end else begin
			sysrst_q <= wr_fire && wr_addr == APP_INTERRUPT_RESET_CTRL_ADDR && wr_bits[SYSRESET_BIT];
		end
	end
	assign sys_reset_req = sysrst_q;

	// tick timer is built only on request; without it its words read zero
	if (TICK_EN) begin : g_tick
		always_ff @(posedge mclk) begin
			if (rst) begin
				tick_run_q <= 1'b0;
				tick_ie_q  <= 1'b0;
			end else if (wr_fire && wr_addr == TICK_CTRL_ADDR && wr_mask[0]) begin
				tick_run_q <= wr_data[TICK_EN_BIT];
				tick_ie_q  <= wr_data[TICK_IE_BIT];
			end
		end
		// reading control clears the flag, as software expects of a poll
		tick_timer u_tick (
			.mclk       (mclk),
			.rst        (rst),
			.run        (tick_run_q),
			.reload_wr  (wr_fire && wr_addr == TICK_RELOAD_ADDR),
			.reload_val (wr_data[TICK_W-1:0]),
			.cur_clr    (wr_fire && wr_addr == TICK_CUR_ADDR),
			.flag_clr   (ar_take && araddr == TICK_CTRL_ADDR),
			.reload_q   (tick_reload),
			.cur_q      (tick_cur),
			.flag_q     (tick_flag),
			.wrap_q     (tick_wrap)
		);
		assign tick_event = tick_wrap && tick_ie_q;
	end else begin : g_no_tick
		assign tick_run_q  = 1'b0;
		assign tick_ie_q   = 1'b0;
		assign tick_reload = '0;
		assign tick_cur    = '0;
		assign tick_flag   = 1'b0;
		assign tick_wrap   = 1'b0;
		assign tick_event  = 1'b0;
	end

	// one synchronous reset serves both domains here; a split power-on and
	// local reset belongs to the integration level

	a_align_fixed_high: assert property (@(posedge mclk) disable iff (rst)
		stack_align_enforce && misaligned_access_trap)
		else $error("alignment controls not fixed high");

	a_fault_escalates: assert property (@(posedge mclk) disable iff (rst)
		(memory_manage_fault || bus_error_fault || usage_error_fault || other_fault)
		|=> severe_fault)
		else $error("fault category did not raise severe fault");

	a_no_fault_quiet: assert property (@(posedge mclk) disable iff (rst)
		!any_fault |=> !severe_fault)
		else $error("severe fault without a cause");

	a_rsvd_reads_zero: assert property (@(posedge mclk) disable iff (rst)
		ar_take && is_rsvd(araddr) |=> rvalid && (rdata == 32'h0000_0000))
		else $error("reserved location returned data");

	a_attr_region_empty: assert property (@(posedge mclk) disable iff (rst)
		ar_take && araddr >= ATTR_REGION_LO && araddr <= ATTR_REGION_HI
		|=> rdata == 32'h0000_0000 ##1 (rdata == 32'h0000_0000 || !rvalid || $changed(rdata)))
		else $error("attribute region returned data");

	a_priority_group_field_razero: assert property (@(posedge mclk) disable iff (rst)
		ar_take && araddr == APP_INTERRUPT_RESET_CTRL_ADDR |=> rdata[10:8] == 3'h0)
		else $error("priority group field not zero");

	a_dbg_port_gate: assert property (@(posedge mclk) disable iff (rst)
		ar_take && !debug_port_sel && (araddr == DEBUG_FAULT_STATUS_REG_ADDR || araddr == HANDLER_CTRL_STATE_REG_ADDR)
		|=> rdata == 32'h0000_0000)
		else $error("debug register visible off the debug port");

	a_severe_sticky: assert property (@(posedge mclk) disable iff (rst)
		severe_fault |=> handler_ctrl_state_reg_q)
		else $error("severe fault not recorded");

	a_watch_halts: assert property (@(posedge mclk) disable iff (rst)
		data_valid && debug_en && watch_q[0][0] && watch_q[0][31:1] == data_addr[31:1]
		&& !$fell(dbg_en_q) |-> ##[2:3] (core_halt_req || !debug_en))
		else $error("watchpoint hit did not request halt");

	a_breakpoint_instruction_marks_debug_fault_status_reg: assert property (@(posedge mclk) disable iff (rst)
		breakpoint_instruction && debug_en |=> debug_fault_status_reg_q[DEBUG_FAULT_STATUS_REG_BREAKPOINT_INSTRUCTION_BIT])
		else $error("breakpoint not logged");

	a_write_answer: assert property (@(posedge mclk) disable iff (rst)
		wr_fire |=> bvalid && bresp == 2'h0 && !awready && !wready)
		else $error("write not answered next cycle");
endmodule : reduced_system_control_space
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the reduced system control space register bank
// assumes scs_pkg and the design are compiled first; this bench is the AXI4-Lite master
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import scs_pkg::*;
	logic        mclk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, fetch_addr = '0, data_addr = '0;
	logic [31:0] pc_sample = '0, rdata, rd;
	logic [31:0] seed = 32'h0000_0017;
	logic [3:0]  wstrb = 4'hf;
	logic        debug_port_sel = 0, memory_manage_fault = 0, bus_error_fault = 0;
	logic        usage_error_fault = 0, other_fault = 0, fetch_valid = 0, data_valid = 0;
	logic        breakpoint_instruction = 0, core_halted = 0;
	logic        awready, wready, bvalid, arready, rvalid, severe_fault, stack_align_enforce;
	logic        misaligned_access_trap, core_halt_req, sys_reset_req, tick_event;
	logic [1:0]  bresp, rresp;
	int          n_errors = 0, checks_done = 0;
	int          cyc = 0, n_sysrst = 0, tick_rl = 3;
	int          tick_at[$];
	// model of the reserved map; attribute region words are appended at run time
	logic [31:0] rsv[$] = '{SYS_CTRL_RSVD, CFG_CTRL_RSVD, HPRIO1_RSVD, CFG_FAULT_RSVD,
		SEV_FAULT_RSVD, MEM_FADDR_RSVD, BUS_FADDR_RSVD, AUX_FAULT_RSVD, COPROC_RSVD, SW_TRIG_RSVD};

	reduced_system_control_space i_dut (.*);

	// free-running 125 MHz clock
	always #4 mclk = ~mclk;

	// event monitor: one-cycle pulses are counted at the edge that samples them
	always @(posedge mclk) begin
		cyc++;
		if (sys_reset_req === 1'b1)
			n_sysrst++;
		if (tick_event === 1'b1)
			tick_at.push_back(cyc);
	end

	// closing report, the only place the run ends
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	// compare one word against the model
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	// write one word; each channel drops at the rising edge that takes it
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic s);
		logic done;
		int   n;
		done = 1'b0;
		@(posedge mclk);
		{awaddr, wdata, awvalid, wvalid, bready, debug_port_sel} <= {a, d, 3'b111, s};
		for (n = 0; n < 40 && !done; n++) begin
			@(posedge mclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			done = (bvalid === 1'b1);
		end
		bready <= 1'b0;
		if (!done) begin
			n_errors++;
			wrap_up();
		end
	endtask : wr

	// read one word into rd; debug_port_sel rides along with the address
	task automatic rdw(input logic [31:0] a, input logic s);
		logic done;
		int   n;
		done = 1'b0;
		@(posedge mclk);
		{araddr, arvalid, rready, debug_port_sel} <= {a, 2'b11, s};
		for (n = 0; n < 40 && !done; n++) begin
			@(posedge mclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			done = (rvalid === 1'b1);
			rd = rdata;
		end
		rready <= 1'b0;
		if (!done) begin
			n_errors++;
			wrap_up();
		end
	endtask : rdw

	// one fault line for one cycle; severe fault must follow one edge later
	task automatic fault(input int k);
		@(posedge mclk);
		{memory_manage_fault, bus_error_fault, usage_error_fault, other_fault} <= 4'b1000 >> k;
		@(posedge mclk);
		{memory_manage_fault, bus_error_fault, usage_error_fault, other_fault} <= 4'h0;
		@(negedge mclk);
		chk("severe_fault", 32'h0000_0001, {31'h0, severe_fault});
	endtask : fault

	// t: 0 fetch match, 1 data address match, 2 breakpoint instruction
	task automatic probe(input int t, input logic [31:0] a);
		@(posedge mclk);
		{fetch_valid, data_valid, breakpoint_instruction} <= 3'b100 >> t;
		{fetch_addr, data_addr} <= {a, a};
		@(posedge mclk);
		{fetch_valid, data_valid, breakpoint_instruction} <= 3'b000;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		chk("halt_req", 32'h0000_0001, {31'h0, core_halt_req});
		// the core answers the request by halting for one cycle, which ends the request
		@(posedge mclk);
		core_halted <= 1'b1;
		@(posedge mclk);
		core_halted <= 1'b0;
		rdw(DEBUG_FAULT_STATUS_REG_ADDR, 1);
		chk("debug_fault_status_reg", (t == 1) ? 32'h0000_0005 : 32'h0000_0003, rd);
		wr(DEBUG_FAULT_STATUS_REG_ADDR, 32'h0000_0007, 1);
		chk("halt_drop", '0, {31'h0, core_halt_req});
	endtask : probe

	// main sequence
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 0;
		for (int i = 0; i < 16; i++)
			rsv.push_back(ATTR_REGION_LO + 32'(4 * i));
		// random writes must leave every reserved word reading zero on either port
		foreach (rsv[i]) begin
			seed = lfsr(seed);
			wr(rsv[i], seed, seed[0]);
			rdw(rsv[i], seed[1]);
			chk("reserved", '0, rd);
		end
		$display("test reserved done");
		chk("align", 32'h0000_0003, {30'h0, stack_align_enforce, misaligned_access_trap});
		wr(APP_INTERRUPT_RESET_CTRL_ADDR, 32'h0000_0700, 0);
		rdw(APP_INTERRUPT_RESET_CTRL_ADDR, 0);
		chk("prio_group", '0, rd);
		chk("no_reset_req", '0, 32'(n_sysrst));
		wr(APP_INTERRUPT_RESET_CTRL_ADDR, 32'h0000_0004, 0);
		rdw(APP_INTERRUPT_RESET_CTRL_ADDR, 0);
		chk("reset_req", 32'h0000_0001, 32'(n_sysrst));
		$display("test fixed done");
		// tick timer: period is reload plus one, flag sticky until a control read
		wr(TICK_RELOAD_ADDR, 32'(tick_rl), 0);
		wr(TICK_CTRL_ADDR, 32'h0000_0003, 0);
		repeat (16) @(posedge mclk);
		wr(TICK_CTRL_ADDR, 32'h0000_0000, 0);
		rdw(TICK_CTRL_ADDR, 0);
		chk("tick_flag", 32'h0001_0000, rd);
		rdw(TICK_CTRL_ADDR, 0);
		chk("tick_flag_clr", '0, rd);
		chk("tick_pulses", 32'h0000_0001, {31'h0, tick_at.size() >= 3});
		chk("tick_period", 32'(tick_rl + 1), 32'(tick_at[1] - tick_at[0]));
		$display("test tick done");
		for (int k = 0; k < 4; k++)
			fault(k);
		rdw(HANDLER_CTRL_STATE_REG_ADDR, 1);
		chk("fault_seen", 32'h0000_0001, rd);
		rdw(HANDLER_CTRL_STATE_REG_ADDR, 0);
		chk("fault_hidden", '0, rd);
		wr(HANDLER_CTRL_STATE_REG_ADDR, 32'h0000_0001, 1);
		rdw(HANDLER_CTRL_STATE_REG_ADDR, 1);
		chk("fault_clear", '0, rd);
		$display("test faults done");
		seed = lfsr(seed);
		pc_sample <= seed;
		rdw(PC_SAMPLE_REG_ADDR, 1);
		chk("pc_sample", seed, rd);
		wr(DBG_CTRL_ADDR, 32'h0000_0001, 1);
		wr(BREAKPOINT_INSTRUCTION_BASE, 32'h0000_1001, 1);
		seed = lfsr(seed);
		wr(BREAKPOINT_INSTRUCTION_BASE, seed, 0);
		rdw(BREAKPOINT_INSTRUCTION_BASE, 1);
		chk("breakpoint_instruction_core_wr", 32'h0000_1001, rd);
		wr(WATCH_BASE, 32'h2000_0041, 1);
		probe(0, 32'h0000_1000);
		probe(1, 32'h2000_0040);
		probe(2, '0);
		$display("test debug done");
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
